// file: common/apc_pkg.sv
// Constants for the attribute and palette stage and its legacy mode registers.
// Assumes a 10-bit I/O port address and 8-bit data from the host bus logic.
package apc_pkg;
  localparam logic [9:0] PORT_ATTR_WR   = 10'h3C0;
  localparam logic [9:0] PORT_ATTR_RD   = 10'h3C1;
  localparam logic [9:0] PORT_STAT_MONO = 10'h3BA;
  localparam logic [9:0] PORT_STAT_CLR  = 10'h3DA;
  localparam logic [9:0] PORT_MODE_MONO = 10'h3B8;
  localparam logic [9:0] PORT_MODE_CLR  = 10'h3D8;
  localparam logic [9:0] PORT_GFX_LOCK  = 10'h3BF;
  localparam logic [9:0] PORT_EXT_MODE  = 10'h3DE;
  localparam logic [4:0] IDX_PAL_LAST   = 5'h0F;
  localparam logic [4:0] IDX_MODE       = 5'h10;
  localparam logic [4:0] IDX_BORDER     = 5'h11;
  localparam logic [4:0] IDX_PLANE      = 5'h12;
  localparam logic [4:0] IDX_PAN        = 5'h13;
  localparam logic [4:0] IDX_COLHI      = 5'h14;
  localparam int         MODE_SRC_HI    = 7;
  localparam int         MODE_WIDE      = 6;
  localparam int         MODE_PANCMP    = 5;
  localparam int         MODE_BLINK     = 3;
  localparam int         MODE_LINEGFX   = 2;
  localparam int         MODE_MONO      = 1;
  localparam int         MODE_GFX       = 0;
  localparam int         INDEX_SRC_BIT  = 5;
  localparam logic [3:0] PAN_NINE_ZERO  = 4'h8;
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [5:0] RST_INDEX      = 6'h00;
  localparam logic [7:0] UNMAPPED_READ  = 8'hFF;
endpackage

// file: rtl/apc_attribute_palette_ctrl.sv
// Attribute and palette stage with index/data toggle and legacy mode registers.
// Assumes same-clock single-cycle host strobes and pixel inputs from the serializer.
`timescale 1ns/10ps
module apc_attribute_palette_ctrl
  import apc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [9:0] ioAddr,
  input  wire logic       ioWr,
  input  wire logic       ioRd,
  input  wire logic [7:0] ioWData,
  output logic      [7:0] ioRData,
  input  wire logic       compatEn,
  input  wire logic       extModeEn,
  input  wire logic       miscColor,
  input  wire logic [3:0] statusIn,
  input  wire logic [3:0] planeIn,
  input  wire logic [7:0] pixel8In,
  input  wire logic [7:0] textAttr,
  input  wire logic       fontDot,
  input  wire logic       ninthDotSlot,
  input  wire logic       lineGfxCode,
  input  wire logic       blinkPhase,
  input  wire logic       borderArea,
  input  wire logic       dot9Mode,
  input  wire logic       lineCompare,
  input  wire logic       vsync,
  output logic      [7:0] pixelOut,
  output logic            pixelClkEn,
  output logic      [3:0] panShift,
  output logic            crtPanMask,
  output logic            monoAttr,
  output logic            graphicsMode,
  output logic      [7:0] monoMode,
  output logic      [7:0] colorMode,
  output logic      [1:0] gfxLock,
  output logic      [7:0] extMode
);

  logic [5:0] palette_q [16];
  logic [7:0] mode_q;
  logic [7:0] border_q;
  logic [7:0] plane_q;
  logic [3:0] pan_q;
  logic [3:0] colHi_q;
  logic [5:0] index_q;
  logic       flip_q;
  logic [7:0] rdata_q;
  logic [7:0] pixel_q;
  logic       pclk_q;
  logic [3:0] shift_q;
  logic       panOff_q;
  logic [3:0] prevIdx_q;
  logic [7:0] monoMode_q;
  logic [7:0] colorMode_q;
  logic [1:0] lock_q;
  logic [7:0] extMode_q;
  logic [3:0] rawIdx;
  logic [3:0] maskIdx;
  logic [3:0] bgIdx;
  logic [7:0] pixel_d;
  logic [7:0] regRead;
  logic [1:0] diagBits;
  logic [3:0] shift_d;

  logic [9:0] statPort;
  logic [9:0] modePort;
  assign statPort = miscColor ? PORT_STAT_CLR : PORT_STAT_MONO;
  assign modePort = miscColor ? PORT_MODE_CLR : PORT_MODE_MONO;

  logic wrAttr;
  logic rdAttrIdx;
  logic rdAttrData;
  logic rdStatus;
  logic wrMode;
  logic wrLock;
  logic wrExt;
  assign wrAttr     = ioWr && ioAddr == PORT_ATTR_WR;
  assign rdAttrIdx  = ioRd && ioAddr == PORT_ATTR_WR;
  assign rdAttrData = ioRd && ioAddr == PORT_ATTR_RD;
  assign rdStatus   = ioRd && ioAddr == statPort;
  assign wrMode     = ioWr && compatEn && ioAddr == modePort;
  assign wrLock     = ioWr && compatEn && ioAddr == PORT_GFX_LOCK;
  assign wrExt      = ioWr && compatEn && extModeEn && ioAddr == PORT_EXT_MODE;

  logic wrData;
  assign wrData = wrAttr && flip_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flip_q <= 1'b0;
    end else if (rdStatus) begin
      flip_q <= 1'b0;
    end else if (wrAttr) begin
      flip_q <= ~flip_q;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      index_q <= RST_INDEX;
    end else if (wrAttr && !flip_q) begin
      index_q <= ioWData[5:0];
    end
  end

  // palette writes only when source bit low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 16; i++) begin
        palette_q[i] <= 6'h00;
      end
    end else if (wrData && !index_q[INDEX_SRC_BIT] && index_q[4:0] <= IDX_PAL_LAST) begin
      palette_q[index_q[3:0]] <= ioWData[5:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_q   <= RST_BYTE;
      border_q <= RST_BYTE;
      plane_q  <= RST_BYTE;
      pan_q    <= 4'h0;
      colHi_q  <= 4'h0;
    end else if (wrData) begin
      case (index_q[4:0])
        IDX_MODE:   mode_q   <= ioWData;
        IDX_BORDER: border_q <= ioWData;
        IDX_PLANE:  plane_q  <= {2'b00, ioWData[5:0]};
        IDX_PAN:    pan_q    <= ioWData[3:0];
        IDX_COLHI:  colHi_q  <= ioWData[3:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    regRead = RST_BYTE;
    if (index_q[4:0] <= IDX_PAL_LAST) begin
      regRead = {2'b00, palette_q[index_q[3:0]]};
    end else begin
      case (index_q[4:0])
        IDX_MODE:   regRead = mode_q;
        IDX_BORDER: regRead = border_q;
        IDX_PLANE:  regRead = plane_q;
        IDX_PAN:    regRead = {4'h0, pan_q};
        IDX_COLHI:  regRead = {4'h0, colHi_q};
        default:    regRead = RST_BYTE;
      endcase
    end
  end

  always_comb begin
    case (plane_q[5:4])
      2'b00:   diagBits = {pixel_q[2], pixel_q[0]};
      2'b01:   diagBits = {pixel_q[5], pixel_q[4]};
      2'b10:   diagBits = {pixel_q[3], pixel_q[1]};
      default: diagBits = {pixel_q[7], pixel_q[6]};
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= RST_BYTE;
    end else if (rdAttrIdx) begin
      rdata_q <= {2'b00, index_q};
    end else if (rdAttrData) begin
      rdata_q <= regRead;
    end else if (rdStatus) begin
      rdata_q <= {2'b00, diagBits, statusIn};
    end else if (ioRd) begin
      rdata_q <= UNMAPPED_READ;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lock_q <= 2'b00;
    end else if (miscColor) begin
      lock_q <= 2'b00;
    end else if (wrLock) begin
      lock_q <= ioWData[1:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      monoMode_q  <= RST_BYTE;
      colorMode_q <= RST_BYTE;
    end else if (wrMode && !miscColor) begin
      monoMode_q <= {ioWData[7] & lock_q[1], 1'b0, ioWData[5], 1'b0,
                     ioWData[3], 1'b0, ioWData[1] & lock_q[0], ioWData[0]};
    end else if (wrMode) begin
      colorMode_q <= {2'b00, ioWData[5:0]};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      extMode_q <= RST_BYTE;
    end else if (wrExt) begin
      extMode_q <= {1'b0, ioWData[6], 2'b00, ioWData[3:2], 1'b0, ioWData[0]};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      panOff_q <= 1'b0;
    end else if (vsync) begin
      panOff_q <= 1'b0;
    end else if (lineCompare && mode_q[MODE_PANCMP]) begin
      panOff_q <= 1'b1;
    end
  end

  always_comb begin
    if (mode_q[MODE_WIDE]) begin
      shift_d = {2'b00, pan_q[2:1]};
    end else if (dot9Mode) begin
      shift_d = (pan_q < PAN_NINE_ZERO) ? pan_q + 4'h1 : 4'h0;
    end else begin
      shift_d = {1'b0, pan_q[2:0]};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shift_q <= 4'h0;
    end else begin
      shift_q <= panOff_q ? 4'h0 : shift_d;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pclk_q <= 1'b0;
    end else begin
      pclk_q <= mode_q[MODE_WIDE] ? ~pclk_q : 1'b1;
    end
  end

  always_comb begin
    bgIdx = mode_q[MODE_BLINK] ? {1'b0, textAttr[6:4]} : textAttr[7:4];
    if (mode_q[MODE_GFX]) begin
      rawIdx = planeIn;
    end else if (ninthDotSlot && lineGfxCode && mode_q[MODE_LINEGFX]) begin
      rawIdx = prevIdx_q;
    end else if (ninthDotSlot) begin
      rawIdx = bgIdx;
    end else if (mode_q[MODE_BLINK] && textAttr[7] && blinkPhase) begin
      rawIdx = bgIdx;
    end else begin
      rawIdx = fontDot ? textAttr[3:0] : bgIdx;
    end
  end

  assign maskIdx = rawIdx & plane_q[3:0];

  always_comb begin
    if (!index_q[INDEX_SRC_BIT]) begin
      pixel_d = 8'h00;
    end else if (borderArea) begin
      pixel_d = border_q;
    end else if (mode_q[MODE_WIDE] && mode_q[MODE_GFX]) begin
      pixel_d = pixel8In;
    end else begin
      pixel_d = {colHi_q[3:2], palette_q[maskIdx]};
      if (mode_q[MODE_SRC_HI]) begin
        pixel_d[5:4] = colHi_q[1:0];
      end
    end
  end

  // Wide mode holds each pixel for two dot clocks
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pixel_q   <= 8'h00;
      prevIdx_q <= 4'h0;
    end else if (!mode_q[MODE_WIDE] || !pclk_q) begin
      pixel_q   <= pixel_d;
      prevIdx_q <= rawIdx;
    end
  end

  assign ioRData      = rdata_q;
  assign pixelOut     = pixel_q;
  assign pixelClkEn   = pclk_q;
  assign panShift     = shift_q;
  assign crtPanMask   = panOff_q;
  assign monoAttr     = mode_q[MODE_MONO];
  assign graphicsMode = mode_q[MODE_GFX];
  assign monoMode     = monoMode_q;
  assign colorMode    = colorMode_q;
  assign gfxLock      = lock_q;
  assign extMode      = extMode_q;

  sequence s_statusRead;
    rdStatus;
  endsequence

  sequence s_attrWrite;
    wrAttr && !rdStatus;
  endsequence

  property p_statusClear;
    @(posedge clk) disable iff (!nrst) s_statusRead |=> !flip_q;
  endproperty
  a_statusClear: assert property (p_statusClear) else $error("toggle not cleared");

  property p_toggle;
    @(posedge clk) disable iff (!nrst) s_attrWrite |=> flip_q != $past(flip_q);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle did not flip");

  property p_readKeep;
    @(posedge clk) disable iff (!nrst) (rdAttrData || rdAttrIdx) && !ioWr |=> $stable(flip_q);
  endproperty
  a_readKeep: assert property (p_readKeep) else $error("read moved toggle");

  property p_blank;
    @(posedge clk) disable iff (!nrst) !index_q[INDEX_SRC_BIT] && !mode_q[MODE_WIDE] |=> pixel_q == 8'h00;
  endproperty
  a_blank: assert property (p_blank) else $error("video not blanked");

  property p_border;
    @(posedge clk) disable iff (!nrst)
      index_q[INDEX_SRC_BIT] && borderArea && !mode_q[MODE_WIDE] |=> pixel_q == $past(border_q);
  endproperty
  a_border: assert property (p_border) else $error("border colour wrong");

  property p_halfClock;
    @(posedge clk) disable iff (!nrst) mode_q[MODE_WIDE] [*2] |=> pclk_q != $past(pclk_q);
  endproperty
  a_halfClock: assert property (p_halfClock) else $error("pixel clock not halved");

  property p_panFreeze;
    @(posedge clk) disable iff (!nrst)
      lineCompare && mode_q[MODE_PANCMP] && !vsync |=> panOff_q ##1 shift_q == 4'h0;
  endproperty
  a_panFreeze: assert property (p_panFreeze) else $error("panning not frozen");

  property p_lockClear;
    @(posedge clk) disable iff (!nrst) miscColor |=> lock_q == 2'b00;
  endproperty
  a_lockClear: assert property (p_lockClear) else $error("lock not cleared");

  property p_diag;
    @(posedge clk) disable iff (!nrst) s_statusRead |=> ioRData[5:4] == $past(diagBits);
  endproperty
  a_diag: assert property (p_diag) else $error("status routing wrong");
endmodule

// file: test/apc_host_model.sv
// Host processor model driving single-cycle I/O strobes on the port bus.
// Assumes the device takes strobes on rising clk and answers reads one cycle later.
`timescale 1ns/10ps
module apc_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] ioRData,
  output logic      [9:0] ioAddr,
  output logic            ioWr,
  output logic            ioRd,
  output logic      [7:0] ioWData
);
  initial begin
    ioAddr  = 10'h000;
    ioWr    = 1'b0;
    ioRd    = 1'b0;
    ioWData = 8'h00;
  end

  // Idle bus shows inverted leftovers, so stale values never look valid
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    ioAddr  = a;
    ioWData = d;
    ioWr    = 1'b1;
    @(posedge clk);
    #1;
    ioWr    = 1'b0;
    ioAddr  = ~a;
    ioWData = ~d;
  endtask

  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    ioAddr = a;
    ioRd   = 1'b1;
    @(posedge clk);
    #1;
    ioRd   = 1'b0;
    ioAddr = ~a;
    d      = ioRData;
  endtask
endmodule

// file: test/tb_top.sv
// Self-checking bench for the attribute and palette stage.
// Assumes the host model issues all port accesses; pixel inputs come from here.
`timescale 1ns/10ps
module tb_top
  import apc_pkg::*;
;
  logic       clk, nrst, ioWr, ioRd, compatEn, extModeEn, miscColor, borderArea;
  logic       dot9Mode, lineCompare, vsync, pixelClkEn, crtPanMask, monoAttr, graphicsMode, pc;
  logic [9:0] ioAddr;
  logic [7:0] ioWData, ioRData, pixel8In, pixelOut, monoMode, colorMode, extMode, rdv;
  logic [3:0] statusIn, planeIn, panShift;
  logic [1:0] gfxLock;
  logic [7:0] textAttr;
  logic       fontDot, ninthDotSlot, lineGfxCode, blinkPhase;
  int         numErrors, nCompared, cycles;
  // Mode, nine-dot flag, pan value, expected shift
  logic [19:0] panTab [7] = '{20'h41063, 20'h41021, 20'h01101, 20'h01178, 20'h01180, 20'h01033, 20'h01077};
  // Mode, plane enable, colour select, expected pixel
  logic [31:0] pixTab [4] = '{32'h010F0CF5, 32'h810F0EE5, 32'h81040EE4, 32'h01040034};
  // Status bits 5:4 per routing code, for border value A5
  localparam logic [7:0] ROUTE = 8'h8B;

  apc_host_model host (.clk, .ioRData, .ioAddr, .ioWr, .ioRd, .ioWData);
  apc_attribute_palette_ctrl uut (
    .clk, .nrst, .ioAddr, .ioWr, .ioRd, .ioWData, .ioRData, .compatEn, .extModeEn, .miscColor,
    .statusIn, .planeIn, .pixel8In, .textAttr, .fontDot, .ninthDotSlot,
    .lineGfxCode, .blinkPhase, .borderArea, .dot9Mode, .lineCompare, .vsync,
    .pixelOut, .pixelClkEn, .panShift, .crtPanMask, .monoAttr, .graphicsMode, .monoMode,
    .colorMode, .gfxLock, .extMode
  );

  always #4 clk = ~clk;

  task automatic report_and_stop();
    if (numErrors == 0 && nCompared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      numErrors++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nCompared++;
    if (got !== exp) begin
      numErrors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic rdchk(input logic [9:0] a, input logic [7:0] exp);
    host.rd(a, rdv);
    chk(rdv, exp);
  endtask

  // Status read first, so the pair always starts with an index write
  task automatic attr(input logic [5:0] idx, input logic [7:0] val);
    host.rd(miscColor ? PORT_STAT_CLR : PORT_STAT_MONO, rdv);
    host.wr(PORT_ATTR_WR, {2'b00, idx});
    host.wr(PORT_ATTR_WR, val);
  endtask

  initial begin
    clk         = 1'b0;
    nrst        = 1'b0;
    compatEn    = 1'b0;
    extModeEn   = 1'b0;
    miscColor   = 1'b1;
    statusIn    = 4'h9;
    planeIn     = 4'h5;
    pixel8In    = 8'h5C;
    borderArea  = 1'b0;
    dot9Mode    = 1'b0;
    lineCompare = 1'b0;
    vsync       = 1'b0;
    textAttr    = 8'h00;
    fontDot     = 1'b0;
    ninthDotSlot = 1'b0;
    lineGfxCode = 1'b0;
    blinkPhase  = 1'b0;
    numErrors   = 0;
    nCompared   = 0;
    cycles      = 0;
    repeat (4) @(posedge clk);
    #1;
    nrst = 1'b1;
    settle();
    chk({7'h00, pixelClkEn}, 8'h01);
    chk({6'h00, gfxLock}, 8'h00);
    attr({1'b0, IDX_MODE}, 8'h41);
    rdchk(PORT_ATTR_RD, 8'h41);
    rdchk(PORT_ATTR_WR, {3'b000, IDX_MODE});
    // Reads above must not have moved the toggle
    host.wr(PORT_ATTR_WR, 8'h31);
    rdchk(PORT_ATTR_WR, 8'h31);
    settle();
    chk(pixelOut, 8'h5C);
    for (int i = 0; i < 3; i++) begin
      pc = pixelClkEn;
      @(posedge clk);
      #1;
      chk({7'h00, pixelClkEn}, {7'h00, ~pc});
    end
    for (int i = 0; i < 7; i++) begin
      dot9Mode = panTab[i][8];
      attr({1'b1, IDX_MODE}, panTab[i][19:12]);
      attr({1'b1, IDX_PAN}, {4'h0, panTab[i][7:4]});
      settle();
      chk({4'h0, panShift}, {4'h0, panTab[i][3:0]});
    end
    // palette loaded only with source bit low
    for (int i = 0; i < 16; i++) attr({1'b0, 5'(i)}, 8'h30 | 8'(i));
    settle();
    chk(pixelOut, 8'h00);
    attr(6'h25, 8'h0F);
    rdchk(PORT_ATTR_RD, 8'h35);
    for (int i = 0; i < 4; i++) begin
      attr({1'b1, IDX_MODE}, pixTab[i][31:24]);
      attr({1'b1, IDX_PLANE}, pixTab[i][23:16]);
      attr({1'b1, IDX_COLHI}, pixTab[i][15:8]);
      settle();
      chk(pixelOut, pixTab[i][7:0]);
    end
    attr({1'b1, IDX_MODE}, 8'h03);
    settle();
    chk({6'h00, monoAttr, graphicsMode}, 8'h03);
    borderArea = 1'b1;
    attr({1'b1, IDX_BORDER}, 8'hA5);
    settle();
    chk(pixelOut, 8'hA5);
    for (int k = 0; k < 4; k++) begin
      attr({1'b1, IDX_PLANE}, {2'b00, 2'(k), 4'hF});
      rdchk(PORT_STAT_CLR, {2'b00, ROUTE[2*k+:2], 4'h9});
    end
    for (int k = 0; k < 2; k++) begin
      attr({1'b1, IDX_MODE}, k == 0 ? 8'h21 : 8'h01);
      lineCompare = 1'b1;
      @(posedge clk);
      #1;
      lineCompare = 1'b0;
      settle();
      chk({7'h00, crtPanMask}, k == 0 ? 8'h01 : 8'h00);
      chk({4'h0, panShift}, k == 0 ? 8'h00 : 8'h07);
      vsync = 1'b1;
      @(posedge clk);
      #1;
      vsync = 1'b0;
      settle();
      chk({7'h00, crtPanMask}, 8'h00);
    end
    // Text path: attribute A3, palette entry n holds 30+n
    borderArea = 1'b0;
    textAttr   = 8'hA3;
    fontDot    = 1'b1;
    blinkPhase = 1'b1;
    attr({1'b1, IDX_MODE}, 8'h08);
    settle();
    chk(pixelOut, 8'h32);
    attr({1'b1, IDX_MODE}, 8'h04);
    settle();
    chk(pixelOut, 8'h33);
    ninthDotSlot = 1'b1;
    lineGfxCode  = 1'b1;
    settle();
    chk(pixelOut, 8'h33);
    attr({1'b1, IDX_MODE}, 8'h00);
    settle();
    chk(pixelOut, 8'h3A);
    ninthDotSlot = 1'b0;
    lineGfxCode  = 1'b0;
    host.wr(PORT_MODE_CLR, 8'h3F);
    settle();
    chk(colorMode, RST_BYTE);
    compatEn = 1'b1;
    host.wr(PORT_MODE_CLR, 8'h3F);
    settle();
    chk(colorMode, 8'h3F);
    miscColor = 1'b0;
    host.wr(PORT_MODE_CLR, 8'h01);
    host.wr(PORT_MODE_MONO, 8'hAB);
    settle();
    chk(colorMode, 8'h3F);
    chk(monoMode, 8'h29);
    host.wr(PORT_GFX_LOCK, 8'h03);
    host.wr(PORT_MODE_MONO, 8'hAB);
    settle();
    chk(monoMode, 8'hAB);
    chk({6'h00, gfxLock}, 8'h03);
    miscColor = 1'b1;
    settle();
    chk({6'h00, gfxLock}, 8'h00);
    host.wr(PORT_EXT_MODE, 8'h4D);
    settle();
    chk(extMode, RST_BYTE);
    extModeEn = 1'b1;
    host.wr(PORT_EXT_MODE, 8'h4D);
    settle();
    chk(extMode, 8'h4D);
    rdchk(10'h300, UNMAPPED_READ);
    // Second reset in mid-run
    nrst = 1'b0;
    @(posedge clk);
    #1;
    nrst = 1'b1;
    settle();
    chk(extMode, RST_BYTE);
    chk(monoMode, RST_BYTE);
    report_and_stop();
  end
endmodule
